// ===== adc_cfg.svh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// ----------------------------------------------------------------
// register map (index on the 3-bit register port)
// ----------------------------------------------------------------
`define ADC_OFS_MAIN 3'h0
`define ADC_OFS_PORT 3'h1
`define ADC_OFS_TIMING 3'h2
`define ADC_OFS_RES_HI 3'h3
`define ADC_OFS_RES_LO 3'h4
`define ADC_OFS_IRQ 3'h5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ADC_MAIN_ON_BIT 0
`define ADC_MAIN_GO_BIT 1
`define ADC_MAIN_CHAN_LSB 2
`define ADC_PORT_VREFN_BIT 4
`define ADC_PORT_VREFP_BIT 5
`define ADC_TIM_JUSTIFY_BIT 7
`define ADC_TIM_ACQ_LSB 3
`define ADC_IRQ_FLAG_BIT 0
`define ADC_IRQ_EN_BIT 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ADC_PORT_RESET_FUSE_SET 4'h0
`define ADC_PORT_RESET_FUSE_CLR 4'h7
`define ADC_TIM_RESET 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ADC_CLK_PERIOD_NS 50
`define ADC_INSTR_CYCLE_CLKS 4
`define ADC_RC_TAD_NS 2500
`define ADC_RC_TAD_CLKS (`ADC_RC_TAD_NS / `ADC_CLK_PERIOD_NS)
`define ADC_CONV_TADS 13

`endif

// ===== adc_pkg.sv
// types and shared decode functions of the converter control
package adc_pkg;

	typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} adc_state_t;

	// oscillator periods per conversion clock period, 0 means internal rc clock
	function automatic logic [6:0] conv_div(input logic [2:0] sel);
		logic [2:0] expo;
		expo = 3'h1 + {2'h0, sel[2]} + {sel[1:0], 1'b0};
		if (sel[1:0] == 2'b11) begin
			conv_div = 7'h00;
		end else begin
			conv_div = 7'(1 << expo);
		end
	endfunction

	// acquisition length in conversion clock periods
	function automatic logic [4:0] acq_tads(input logic [2:0] sel);
		case (sel)
			3'h0: acq_tads = 5'h00;
			3'h1: acq_tads = 5'h02;
			3'h2: acq_tads = 5'h04;
			3'h3: acq_tads = 5'h06;
			3'h4: acq_tads = 5'h08;
			3'h5: acq_tads = 5'h0C;
			3'h6: acq_tads = 5'h10;
			default: acq_tads = 5'h14;
		endcase
	endfunction

endpackage

// ===== adc_clock_gen.sv
// conversion clock enable generator: oscillator divider or internal rc timer
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg.svh"
module adc_clock_gen import adc_pkg::*; (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic run_in,
	input wire logic sleep_in,
	input wire logic [2:0] conv_clock_sel_in,
	output logic tad_tick_out
);
	typedef struct packed {
		logic [6:0] cnt;
		logic [2:0] dly;
		logic tick;
	} cg_t;

	cg_t cur_ff, nxt_cur;
	logic [6:0] div;

	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.tick = 1'b0;
		div = conv_div(conv_clock_sel_in);
		if (!run_in) begin
			nxt_cur.cnt = 7'h00;
			nxt_cur.dly = 3'h0;
		end else if (div == 7'h00) begin
			// one instruction cycle of hold-off lets the core enter sleep first
			if (cur_ff.dly != 3'(`ADC_INSTR_CYCLE_CLKS)) begin
				nxt_cur.dly = cur_ff.dly + 3'h1;
			end else if (cur_ff.cnt == 7'(`ADC_RC_TAD_CLKS - 1)) begin
				nxt_cur.cnt = 7'h00;
				nxt_cur.tick = 1'b1;
			end else begin
				nxt_cur.cnt = cur_ff.cnt + 7'h01;
			end
		end else if (!sleep_in) begin
			// oscillator derived clock stops while the core sleeps
			if (cur_ff.cnt == div - 7'h01) begin
				nxt_cur.cnt = 7'h00;
				nxt_cur.tick = 1'b1;
			end else begin
				nxt_cur.cnt = cur_ff.cnt + 7'h01;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign tad_tick_out = cur_ff.tick;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	chk_rc_start_delay: assert property ($rose(run_in) && conv_clock_sel_in[1:0] == 2'b11 |-> !tad_tick_out [*6]) else $error("rc clock started without delay");
	chk_sleep_halt: assert property (sleep_in && conv_clock_sel_in[1:0] != 2'b11 && $past(sleep_in) |-> !tad_tick_out) else $error("oscillator tick during sleep");
endmodule
`default_nettype wire

// ===== adc_sar_core.sv
// successive approximation engine, one decision per conversion clock tick after a first setup tick
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg.svh"
module adc_sar_core import adc_pkg::*; (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire logic abort_in,
	input wire logic tick_in,
	input wire logic comp_in,
	output logic done_out,
	output logic [11:0] result_out,
	output logic [11:0] dac_code_out
);
	typedef struct packed {
		logic busy;
		logic [3:0] step;
		logic [11:0] sar;
		logic [11:0] mask;
		logic [11:0] result;
		logic done;
	} sar_t;

	sar_t cur_ff, nxt_cur;
	logic [11:0] kept;
	logic [4:0] chk_ticks_ff;

	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.done = 1'b0;
		kept = comp_in ? cur_ff.sar : (cur_ff.sar & ~cur_ff.mask);
		if (abort_in) begin
			nxt_cur.busy = 1'b0;
		end else if (start_in) begin
			nxt_cur.busy = 1'b1;
			nxt_cur.step = 4'h0;
			nxt_cur.sar = 12'h000;
		end else if (cur_ff.busy && tick_in) begin
			// first tick sets up the trial word, then twelve bit decisions
			if (cur_ff.step == 4'h0) begin
				nxt_cur.sar = 12'h800;
				nxt_cur.mask = 12'h800;
			end else begin
				nxt_cur.sar = kept | (cur_ff.mask >> 1);
				nxt_cur.mask = cur_ff.mask >> 1;
			end
			nxt_cur.step = cur_ff.step + 4'h1;
			if (cur_ff.step == 4'(`ADC_CONV_TADS - 1)) begin
				nxt_cur.busy = 1'b0;
				nxt_cur.done = 1'b1;
				nxt_cur.result = kept;
				nxt_cur.sar = kept;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cur_ff <= '0;
			chk_ticks_ff <= 5'h00;
		end else begin
			cur_ff <= nxt_cur;
			if (start_in) begin
				chk_ticks_ff <= 5'h00;
			end else if (cur_ff.busy && tick_in) begin
				chk_ticks_ff <= chk_ticks_ff + 5'h01;
			end
		end
	end

	assign done_out = cur_ff.done;
	assign result_out = cur_ff.result;
	assign dac_code_out = cur_ff.sar;

	chk_conv_length: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		done_out |-> chk_ticks_ff == 5'd13) else $error("conversion not thirteen ticks");
endmodule
`default_nettype wire

// ===== adc_sequencing_control.sv
// converter sequencing control: registers, acquisition timer, conversion and result loading
// Notes on behaviour
// - port field resets from fuse: 0000 or 0111
// - port field picks analog/digital pin pattern
// - rc clock starts one instruction cycle late
// - conversion continues in sleep on rc clock
// - reference is supply rails or external pins
// - result by successive approximation of held sample
// - reset restores registers, switches off, aborts
// - completion loads result, clears start, sets flag
// - result undefined at power-up, kept otherwise
// - optional programmed acquisition before conversion
// - nonzero acquisition samples first, zero converts now
// - clock select: 2..64 oscillator periods or rc
// - conversion takes thirteen conversion clock periods
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg.svh"
module adc_sequencing_control import adc_pkg::*; (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic portb_analog_fuse_in,
	input wire logic comparator_in,
	input wire logic sleep_in,
	output logic [12:0] analog_pin_mask_out,
	output logic [3:0] chan_sel_out,
	output logic vref_pos_ext_out,
	output logic vref_neg_ext_out,
	output logic sample_out,
	output logic [11:0] dac_code_out,
	output logic converter_irq_flag_out,
	output logic irq_req_out
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		adc_state_t state;
		logic module_on;
		logic go;
		logic [3:0] chan;
		logic [3:0] port_config_field;
		logic vref_pos_ext;
		logic vref_neg_ext;
		logic result_justify_sel;
		logic [2:0] acquisition_time_sel;
		logic [2:0] conv_clock_sel;
		logic converter_irq_flag;
		logic converter_irq_enable;
		logic [4:0] acq_cnt;
		logic [1:0] strap_wait;
		logic strap_done;
		logic fuse_s1;
		logic fuse_s2;
		// comparator needs no synchroniser: it resolves our own registered trial code
		logic conv_start;
		logic conv_abort;
		logic sample;
		logic irq_req;
		logic [12:0] analog_mask;
		logic [7:0] rdata;
	} ctl_t;

	// result pair is kept apart: it has no reset at all
	typedef struct packed {
		logic [7:0] result_high;
		logic [7:0] result_low;
	} res_t;

	ctl_t cur_ff, nxt_cur;
	res_t res_ff, nxt_res;

	logic tad_tick;
	logic core_done;
	logic [11:0] core_result;
	logic clk_run;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// number of analog pins for a port code: codes 0..2 all thirteen, then one fewer each
	function automatic logic [12:0] port_mask(input logic [3:0] code);
		logic [3:0] cnt;
		cnt = (code <= 4'h2) ? 4'hD : (4'hF - code);
		port_mask = 13'((14'h0001 << cnt) - 14'h0001);
	endfunction

	function automatic logic [15:0] justify(input logic right, input logic [11:0] val);
		if (right) begin
			justify = {4'h0, val};
		end else begin
			justify = {val, 4'h0};
		end
	endfunction

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	assign clk_run = cur_ff.module_on && (cur_ff.state != ST_IDLE);

	adc_clock_gen u_clock_gen (
		.core_clk_in(core_clk_in),
		.rstn_in(rstn_in),
		.run_in(clk_run),
		.sleep_in(sleep_in),
		.conv_clock_sel_in(cur_ff.conv_clock_sel),
		.tad_tick_out(tad_tick)
	);

	adc_sar_core u_sar_core (
		.core_clk_in(core_clk_in),
		.rstn_in(rstn_in),
		.start_in(cur_ff.conv_start),
		.abort_in(cur_ff.conv_abort),
		.tick_in(tad_tick),
		.comp_in(comparator_in),
		.done_out(core_done),
		.result_out(core_result),
		.dac_code_out(dac_code_out)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_cur = cur_ff;
		nxt_res = res_ff;
		nxt_cur.conv_start = 1'b0;
		nxt_cur.conv_abort = 1'b0;
		nxt_cur.rdata = 8'h00;
		nxt_cur.fuse_s1 = portb_analog_fuse_in;
		nxt_cur.fuse_s2 = cur_ff.fuse_s1;
		// two flops on the comparator would leave the fastest conversion clock
		// deciding each bit on the previous trial code

		// fuse level is taken once its synchroniser has settled after reset
		if (!cur_ff.strap_done) begin
			if (cur_ff.strap_wait == 2'h2) begin
				nxt_cur.strap_done = 1'b1;
				nxt_cur.port_config_field = cur_ff.fuse_s2 ?
					`ADC_PORT_RESET_FUSE_SET : `ADC_PORT_RESET_FUSE_CLR;
			end else begin
				nxt_cur.strap_wait = cur_ff.strap_wait + 2'h1;
			end
		end

		// register writes
		if (reg_wr_in) begin
			case (reg_addr_in)
				`ADC_OFS_MAIN: begin
					nxt_cur.module_on = reg_wdata_in[`ADC_MAIN_ON_BIT];
					nxt_cur.go = reg_wdata_in[`ADC_MAIN_GO_BIT] & reg_wdata_in[`ADC_MAIN_ON_BIT];
					nxt_cur.chan = reg_wdata_in[`ADC_MAIN_CHAN_LSB +: 4];
				end
				`ADC_OFS_PORT: begin
					nxt_cur.port_config_field = reg_wdata_in[3:0];
					nxt_cur.vref_neg_ext = reg_wdata_in[`ADC_PORT_VREFN_BIT];
					nxt_cur.vref_pos_ext = reg_wdata_in[`ADC_PORT_VREFP_BIT];
				end
				`ADC_OFS_TIMING: begin
					// bit 6 has no storage
					nxt_cur.result_justify_sel = reg_wdata_in[`ADC_TIM_JUSTIFY_BIT];
					nxt_cur.acquisition_time_sel = reg_wdata_in[`ADC_TIM_ACQ_LSB +: 3];
					nxt_cur.conv_clock_sel = reg_wdata_in[2:0];
				end
				`ADC_OFS_IRQ: begin
					// writing zero clears the flag; a completion in the same cycle still sets it
					nxt_cur.converter_irq_flag = cur_ff.converter_irq_flag &
						reg_wdata_in[`ADC_IRQ_FLAG_BIT];
					nxt_cur.converter_irq_enable = reg_wdata_in[`ADC_IRQ_EN_BIT];
				end
				default: begin
				end
			endcase
		end

		// register reads, data valid in the next cycle only
		if (reg_rd_in) begin
			case (reg_addr_in)
				`ADC_OFS_MAIN: nxt_cur.rdata = {2'b00, cur_ff.chan, cur_ff.go, cur_ff.module_on};
				`ADC_OFS_PORT: nxt_cur.rdata = {2'b00, cur_ff.vref_pos_ext,
					cur_ff.vref_neg_ext, cur_ff.port_config_field};
				`ADC_OFS_TIMING: nxt_cur.rdata = {cur_ff.result_justify_sel, 1'b0,
					cur_ff.acquisition_time_sel, cur_ff.conv_clock_sel};
				`ADC_OFS_RES_HI: nxt_cur.rdata = res_ff.result_high;
				`ADC_OFS_RES_LO: nxt_cur.rdata = res_ff.result_low;
				`ADC_OFS_IRQ: nxt_cur.rdata = {6'h00, cur_ff.converter_irq_enable,
					cur_ff.converter_irq_flag};
				default: nxt_cur.rdata = 8'h00;
			endcase
		end

		// sequencer
		case (cur_ff.state)
			ST_IDLE: begin
				if (cur_ff.go && cur_ff.module_on) begin
					if (cur_ff.acquisition_time_sel == 3'h0) begin
						nxt_cur.state = ST_CONV;
						nxt_cur.conv_start = 1'b1;
					end else begin
						nxt_cur.state = ST_ACQ;
						nxt_cur.acq_cnt = acq_tads(cur_ff.acquisition_time_sel);
					end
				end
			end
			ST_ACQ: begin
				if (!nxt_cur.go || !nxt_cur.module_on) begin
					nxt_cur.state = ST_IDLE;
				end else if (tad_tick) begin
					nxt_cur.acq_cnt = cur_ff.acq_cnt - 5'h01;
					if (cur_ff.acq_cnt == 5'h01) begin
						nxt_cur.state = ST_CONV;
						nxt_cur.conv_start = 1'b1;
					end
				end
			end
			ST_CONV: begin
				if (core_done) begin
					{nxt_res.result_high, nxt_res.result_low} =
						justify(cur_ff.result_justify_sel, core_result);
					nxt_cur.go = 1'b0;
					nxt_cur.converter_irq_flag = 1'b1;
					nxt_cur.state = ST_IDLE;
				end else if (!nxt_cur.go || !nxt_cur.module_on) begin
					// software dropping the start bit or the module abandons the conversion
					nxt_cur.conv_abort = 1'b1;
					nxt_cur.state = ST_IDLE;
				end
			end
			default: begin
				nxt_cur.state = ST_IDLE;
			end
		endcase

		// hold capacitor tracks the input while the module is on and not converting
		nxt_cur.sample = nxt_cur.module_on && (nxt_cur.state != ST_CONV);
		nxt_cur.analog_mask = port_mask(nxt_cur.port_config_field);
		nxt_cur.irq_req = nxt_cur.converter_irq_flag & nxt_cur.converter_irq_enable;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cur_ff <= '0;
			cur_ff.analog_mask <= 13'h1FFF;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// no reset: the pair survives every reset, and is unknown only at power-up
	always_ff @(posedge core_clk_in) begin
		res_ff <= nxt_res;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata_out = cur_ff.rdata;
	assign analog_pin_mask_out = cur_ff.analog_mask;
	assign chan_sel_out = cur_ff.chan;
	assign vref_pos_ext_out = cur_ff.vref_pos_ext;
	assign vref_neg_ext_out = cur_ff.vref_neg_ext;
	assign sample_out = cur_ff.sample;
	assign converter_irq_flag_out = cur_ff.converter_irq_flag;
	assign irq_req_out = cur_ff.irq_req;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	chk_strap_load: assert property ($rose(cur_ff.strap_done) |->
		cur_ff.port_config_field == ($past(cur_ff.fuse_s2) ? 4'h0 : 4'h7))
		else $error("port field not loaded from fuse");

	chk_mask_all_digital: assert property (cur_ff.port_config_field == 4'hF ##1
		$stable(cur_ff.port_config_field) |-> analog_pin_mask_out == 13'h0000)
		else $error("code 1111 left an analog pin");

	chk_mask_seven: assert property (cur_ff.port_config_field == 4'h7 ##1
		$stable(cur_ff.port_config_field) |-> analog_pin_mask_out == 13'h00FF)
		else $error("code 0111 wrong pattern");

	chk_zero_acq_start: assert property (cur_ff.state == ST_IDLE && cur_ff.go &&
		cur_ff.module_on && cur_ff.acquisition_time_sel == 3'h0 |=>
		cur_ff.state == ST_CONV && cur_ff.conv_start && !sample_out)
		else $error("manual acquisition did not convert at once");

	chk_prog_acq_start: assert property (cur_ff.state == ST_IDLE && cur_ff.go &&
		cur_ff.module_on && cur_ff.acquisition_time_sel != 3'h0 |=>
		cur_ff.state == ST_ACQ && cur_ff.acq_cnt == acq_tads($past(cur_ff.acquisition_time_sel)))
		else $error("programmed acquisition not entered");

	chk_acq_hold: assert property (cur_ff.state == ST_ACQ && !tad_tick && cur_ff.go &&
		!(reg_wr_in && reg_addr_in == `ADC_OFS_MAIN) |=> cur_ff.state == ST_ACQ && sample_out)
		else $error("acquisition ended without a tick");

	chk_done_effects: assert property (cur_ff.state == ST_CONV && core_done |=>
		!cur_ff.go && converter_irq_flag_out && cur_ff.state == ST_IDLE &&
		{res_ff.result_high, res_ff.result_low} ==
		justify($past(cur_ff.result_justify_sel), $past(core_result)))
		else $error("completion effects missing");

	chk_bit6_zero: assert property (reg_rd_in && reg_addr_in == `ADC_OFS_TIMING |=>
		reg_rdata_out[6] == 1'b0 && reg_rdata_out[5:3] == $past(cur_ff.acquisition_time_sel))
		else $error("timing read wrong");

	chk_justify_right: assert property (cur_ff.state == ST_CONV && core_done &&
		cur_ff.result_justify_sel |=> res_ff.result_high[7:4] == 4'h0)
		else $error("right justified result has high bits");

	chk_off_idle: assert property (!cur_ff.module_on |-> ##1 (cur_ff.state == ST_IDLE ||
		cur_ff.module_on) && (!cur_ff.go || cur_ff.module_on))
		else $error("switched off block still busy");

endmodule
`default_nettype wire

// ===== adc_sequencing_control_tb.sv
// self-checking testbench for the converter sequencing control
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg.svh"
module adc_sequencing_control_tb import adc_pkg::*;;
	logic core_clk_in, rstn_in, reg_wr_in, reg_rd_in, portb_analog_fuse_in, sleep_in;
	logic [2:0] reg_addr_in;
	logic [7:0] reg_wdata_in, reg_rdata_out;
	logic comparator_in, vref_pos_ext_out, vref_neg_ext_out, sample_out;
	logic [12:0] analog_pin_mask_out;
	logic [3:0] chan_sel_out;
	logic [11:0] dac_code_out, vin;
	logic converter_irq_flag_out, irq_req_out, rd_seen, just;
	logic [15:0] exp_q[$];
	logic [15:0] e;
	logic [31:0] seed;
	int n_fail, compares, t, t_fast;
	int acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
	int div_tab[8] = '{2, 8, 32, 0, 4, 16, 64, 0};

	adc_sequencing_control u_dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.portb_analog_fuse_in(portb_analog_fuse_in), .comparator_in(comparator_in),
		.sleep_in(sleep_in), .analog_pin_mask_out(analog_pin_mask_out),
		.chan_sel_out(chan_sel_out), .vref_pos_ext_out(vref_pos_ext_out),
		.vref_neg_ext_out(vref_neg_ext_out), .sample_out(sample_out),
		.dac_code_out(dac_code_out), .converter_irq_flag_out(converter_irq_flag_out),
		.irq_req_out(irq_req_out));

	// analog input modelled as an ideal comparator against the trial code
	assign comparator_in = (vin >= dac_code_out);

	initial begin
		core_clk_in = 1'b0;
		forever #25 core_clk_in = ~core_clk_in;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic rng(input int v, input int lo, input int hi, input string what);
		cmp(16'(v >= lo && v <= hi), 16'h0001, what);
	endtask

	task automatic test_done;
		$display("compares %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// --------------------------------------------------------
	// register port master; the gap cycle keeps strobes single
	// --------------------------------------------------------
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] mask);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		exp_q.push_back({mask, exp});
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
	endtask

	// --------------------------------------------------------
	// read data monitor: stands only in the cycle after the strobe
	// --------------------------------------------------------
	always @(posedge core_clk_in) rd_seen <= reg_rd_in;
	always @(negedge core_clk_in) begin
		if (rd_seen && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			cmp({8'h00, reg_rdata_out & e[15:8]}, {8'h00, e[7:0] & e[15:8]}, "read data");
		end
	end

	task automatic do_reset(input logic fuse);
		portb_analog_fuse_in <= fuse;
		rstn_in <= 1'b0;
		repeat (8) @(posedge core_clk_in);
		rstn_in <= 1'b1;
		repeat (5) @(posedge core_clk_in);
	endtask

	task automatic wait_flag(input int lim, output int n);
		n = 0;
		while (converter_irq_flag_out !== 1'b1 && n < lim) begin
			@(posedge core_clk_in);
			#1;
			n++;
		end
	endtask

	task automatic convert(input logic [3:0] ch, input int lim, output int n);
		seed = lfsr(seed);
		vin <= seed[11:0];
		repeat (4) @(posedge core_clk_in);
		repeat (124) @(posedge core_clk_in);
		wr(3'h0, {2'b00, ch, 2'b11});
		wait_flag(lim, n);
	endtask

	task automatic chk_result;
		if (just) begin
			rd(3'h3, {4'h0, vin[11:8]}, 8'hFF);
			rd(3'h4, vin[7:0], 8'hFF);
		end else begin
			rd(3'h3, vin[11:4], 8'hFF);
			rd(3'h4, {vin[3:0], 4'h0}, 8'hFF);
		end
	endtask

	initial begin
		repeat (30000) @(posedge core_clk_in);
		n_fail++;
		test_done();
	end

	initial begin
		rstn_in = 1'b0;
		reg_addr_in = 3'h0;
		reg_wdata_in = 8'h00;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		portb_analog_fuse_in = 1'b0;
		sleep_in = 1'b0;
		vin = 12'h000;
		seed = 32'hf02d;
		n_fail = 0;
		compares = 0;
		do_reset(1'b0);
		rd(3'h1, 8'h07, 8'hFF);
		rd(3'h2, 8'h00, 8'hFF);
		rd(3'h6, 8'h00, 8'hFF);
		cmp({3'h0, analog_pin_mask_out}, 16'h00FF, "mask after reset");
		$display("reset values test done");
		for (int c = 0; c < 16; c++) begin
			wr(3'h1, {2'b00, 2'(c), 4'(c)});
			@(posedge core_clk_in);
			#1;
			cmp({3'h0, analog_pin_mask_out},
				(c < 3) ? 16'h1FFF : 16'((32'h1 << (15 - c)) - 1), "pin mask");
			cmp({14'h0, vref_pos_ext_out, vref_neg_ext_out}, 16'(c & 3), "vref");
			rd(3'h1, {2'b00, 2'(c), 4'(c)}, 8'hFF);
		end
		wr(3'h2, 8'hFF);
		rd(3'h2, 8'hBF, 8'hFF);
		$display("port and timing field test done");
		wr(3'h2, 8'h00);
		convert(4'h2, 500, t_fast);
		rng(t_fast, 26, 34, "conversion length");
		cmp({12'h0, chan_sel_out}, 16'h0002, "channel");
		cmp({15'h0, sample_out}, 16'h0001, "sampling after done");
		rd(3'h0, 8'h09, 8'h3F);
		for (int k = 0; k < 8; k++) begin
			wr(3'h5, 8'h00);
			wr(3'h2, {2'b00, 3'(k), 3'b000});
			convert(4'h1, 500, t);
			rng(t - t_fast, 2 * acq_tab[k] - 2, 2 * acq_tab[k] + 2, "acquisition");
		end
		$display("acquisition test done");
		for (int k = 0; k < 7; k++) begin
			if (k != 3) begin
				just = 1'(k);
				wr(3'h5, 8'h00);
				wr(3'h2, {just, 4'h0, 3'(k)});
				convert(4'(k), 2000, t);
				rng(t, 13 * div_tab[k], 15 * div_tab[k] + 8, "clock select");
				chk_result();
			end
		end
		$display("clock select and result test done");
		wr(3'h5, 8'h02);
		wr(3'h2, 8'h83);
		just = 1'b1;
		sleep_in <= 1'b1;
		convert(4'h3, 1000, t);
		rng(t, 654, 720, "rc conversion in sleep");
		cmp({14'h0, converter_irq_flag_out, irq_req_out}, 16'h0003, "flag");
		chk_result();
		wr(3'h5, 8'h02);
		wr(3'h2, 8'h80);
		convert(4'h0, 200, t);
		cmp(16'(t), 16'd200, "oscillator clock held in sleep");
		sleep_in <= 1'b0;
		wait_flag(200, t);
		rng(t, 1, 199, "resume after sleep");
		chk_result();
		$display("sleep test done");
		wr(3'h5, 8'h00);
		wr(3'h2, 8'hAD);
		wr(3'h0, 8'h0B);
		vin <= ~vin;
		repeat (40) @(posedge core_clk_in);
		do_reset(1'b1);
		vin <= ~vin;
		wait_flag(600, t);
		cmp(16'(t), 16'd600, "no completion after reset");
		rd(3'h2, 8'h00, 8'hFF);
		rd(3'h0, 8'h00, 8'h03);
		rd(3'h1, 8'h00, 8'hFF);
		cmp({3'h0, analog_pin_mask_out}, 16'h1FFF, "mask with fuse set");
		wr(3'h2, 8'h80);
		chk_result();
		$display("reset abort test done");
		repeat (4) @(posedge core_clk_in);
		test_done();
	end
endmodule
`default_nettype wire
